// file: src/custom_a_cfg.svh
/*
 Register indices, field positions and reset values of the Custom A
 reference configuration bank. Assumes 8-bit registers on a 32-bit bus.
*/
`ifndef CUSTOM_A_CFG_SVH
`define CUSTOM_A_CFG_SVH

`define IDX_MULT_LO 8'h67
`define IDX_MULT_HI 8'h68
`define IDX_SCM_MIN 8'h69
`define IDX_SCM_MAX 8'h6A
`define IDX_CFM_MIN_LO 8'h6B
`define IDX_CFM_MIN_HI 8'h6C
`define IDX_CFM_MAX_LO 8'h6D
`define IDX_CTRL 8'hF0
`define IDX_STATUS 8'hF1

`define RST_BYTE 8'h00
`define RST_MULT_HI 6'h00
`define RST_CTRL 1'b0
`define RST_WRITTEN 7'h00

`define MULT_HI_MSB 5
`define CTRL_HOLD_BIT 0
`define STATUS_ALL_BIT 7
`define FREQ_STEP_KHZ 17'h00008

`endif

// file: src/custom_a_config.sv
/*
 Custom A reference frequency configuration bank: multiplier, single
 cycle monitor bounds and cycle frequency monitor bounds, reached over
 a classic Wishbone slave, with assembled values driven to the monitors.
 Register map, by index:
  0x67 multiplier bits 7:0
  0x68 multiplier bits 13:8 in 5:0, bits 7:6 reserved, read as zero
  0x69 single cycle monitor lower bound
  0x6A single cycle monitor upper bound
  0x6B/0x6C cycle frequency monitor lower bound, low/high byte
  0x6D cycle frequency monitor upper bound, low byte
  0xF0 control, bit 0 freezes the monitor outputs
  0xF1 status, bits 6:0 written flags, bit 7 all written, write 1 clears
 Assumes one clock, synchronous reset, and 8-bit registers placed one
 per 32-bit word at byte address four times the register index.
*/
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "custom_a_cfg.svh"
module custom_a_config import custom_a_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic [13:0] custom_a_multiplier_o,
	output logic [16:0] custom_a_nominal_khz_o,
	output logic [7:0] custom_a_single_cycle_min_o,
	output logic [7:0] custom_a_single_cycle_max_o,
	output logic [15:0] custom_a_cycle_freq_min_o,
	output logic [7:0] custom_a_cycle_freq_max_low_byte_o
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	typedef struct packed {
		byte_t custom_a_multiplier_low_byte;
		logic [`MULT_HI_MSB:0] custom_a_multiplier_high_bits;
		byte_t custom_a_single_cycle_min;
		byte_t custom_a_single_cycle_max;
		byte_t custom_a_cycle_freq_min_low_byte;
		byte_t custom_a_cycle_freq_min_high_byte;
		byte_t custom_a_cycle_freq_max_low_byte;
		logic hold;
		logic [6:0] written;
	} regs_s;

	regs_s cur;
	regs_s next_cur;
	limits_s live;
	limits_s shown;
	logic write_hit;
	logic [6:0] written_set;
	logic [6:0] written_clear;
	logic [6:0] entry_hit;

	reg_access_if acc ();

	// ----------------------------------------------------------------
	// per-entry address decode
	// ----------------------------------------------------------------
	// entries sit at consecutive indices; bit k of the mask is entry k
	for (genvar gi = 0; gi < 7; gi++) begin : g_entry
		assign entry_hit[gi] = acc.index == (`IDX_MULT_LO + 8'(gi));
	end

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	wb_frontend u_front (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.acc(acc.bus_side)
	);

	// ----------------------------------------------------------------
	// write decode and register update
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		write_hit = acc.req && acc.we && acc.lane_en;
		written_set = write_hit ? entry_hit : 7'h00;
		written_clear = 7'h00;
		if (write_hit) begin
			case (acc.index)
				`IDX_MULT_LO: begin
					next_cur.custom_a_multiplier_low_byte = acc.wdata;
				end
				`IDX_MULT_HI: begin
					// top two bits reserved: never stored, read as zero
					next_cur.custom_a_multiplier_high_bits = acc.wdata[`MULT_HI_MSB:0];
				end
				`IDX_SCM_MIN: begin
					next_cur.custom_a_single_cycle_min = acc.wdata;
				end
				`IDX_SCM_MAX: begin
					next_cur.custom_a_single_cycle_max = acc.wdata;
				end
				`IDX_CFM_MIN_LO: begin
					next_cur.custom_a_cycle_freq_min_low_byte = acc.wdata;
				end
				`IDX_CFM_MIN_HI: begin
					next_cur.custom_a_cycle_freq_min_high_byte = acc.wdata;
				end
				`IDX_CFM_MAX_LO: begin
					next_cur.custom_a_cycle_freq_max_low_byte = acc.wdata;
				end
				`IDX_CTRL: begin
					next_cur.hold = acc.wdata[`CTRL_HOLD_BIT];
				end
				`IDX_STATUS: begin
					written_clear = acc.wdata[6:0];
				end
				default: begin
					// unmapped: acknowledged, nothing stored
				end
			endcase
		end
		// a byte written in the clear cycle stays flagged
		next_cur.written = (cur.written & ~written_clear) | written_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur <= '{
				`RST_BYTE,
				`RST_MULT_HI,
				`RST_BYTE,
				`RST_BYTE,
				`RST_BYTE,
				`RST_BYTE,
				`RST_BYTE,
				`RST_CTRL,
				`RST_WRITTEN
			};
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		acc.rdata = 8'h00;
		case (acc.index)
			`IDX_MULT_LO: begin
				acc.rdata = cur.custom_a_multiplier_low_byte;
			end
			`IDX_MULT_HI: begin
				acc.rdata = {2'h0, cur.custom_a_multiplier_high_bits};
			end
			`IDX_SCM_MIN: begin
				acc.rdata = cur.custom_a_single_cycle_min;
			end
			`IDX_SCM_MAX: begin
				acc.rdata = cur.custom_a_single_cycle_max;
			end
			`IDX_CFM_MIN_LO: begin
				acc.rdata = cur.custom_a_cycle_freq_min_low_byte;
			end
			`IDX_CFM_MIN_HI: begin
				acc.rdata = cur.custom_a_cycle_freq_min_high_byte;
			end
			`IDX_CFM_MAX_LO: begin
				acc.rdata = cur.custom_a_cycle_freq_max_low_byte;
			end
			`IDX_CTRL: begin
				acc.rdata = {7'h00, cur.hold};
			end
			`IDX_STATUS: begin
				acc.rdata = {&cur.written, cur.written};
			end
			default: begin
				acc.rdata = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// value assembly toward the monitors
	// ----------------------------------------------------------------
	always_comb begin
		live.multiplier = {cur.custom_a_multiplier_high_bits,
			cur.custom_a_multiplier_low_byte};
		live.scm_min = cur.custom_a_single_cycle_min;
		live.scm_max = cur.custom_a_single_cycle_max;
		live.cfm_min = {cur.custom_a_cycle_freq_min_high_byte,
			cur.custom_a_cycle_freq_min_low_byte};
		live.cfm_max_lo = cur.custom_a_cycle_freq_max_low_byte;
	end

	// whole values only leave here; hold freezes them during updates
	limit_assembler u_asm (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.live_i(live),
		.hold_i(cur.hold),
		.limits_o(shown),
		.nominal_khz_o(custom_a_nominal_khz_o)
	);

	assign custom_a_multiplier_o = shown.multiplier;
	assign custom_a_single_cycle_min_o = shown.scm_min;
	assign custom_a_single_cycle_max_o = shown.scm_max;
	assign custom_a_cycle_freq_min_o = shown.cfm_min;
	assign custom_a_cycle_freq_max_low_byte_o = shown.cfm_max_lo;
endmodule // custom_a_config

// file: src/custom_a_pkg.sv
/*
 Types shared by the Custom A configuration bank modules.
 Assumes custom_a_cfg.svh supplies the numeric constants.
*/
package custom_a_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_e;
	typedef struct packed {
		logic [13:0] multiplier;
		byte_t scm_min;
		byte_t scm_max;
		logic [15:0] cfm_min;
		byte_t cfm_max_lo;
	} limits_s;
endpackage

// file: src/limit_assembler.sv
/*
 Presents the assembled Custom A values to the reference monitors.
 Assumes the live values come from registers on the same clock.
*/
`timescale 1ns/1ns
`include "custom_a_cfg.svh"
module limit_assembler import custom_a_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire limits_s live_i,
	input wire logic hold_i,
	output limits_s limits_o,
	output logic [16:0] nominal_khz_o
);
	typedef struct packed {
		limits_s held;
		logic [16:0] khz;
	} asm_s;

	asm_s cur;
	asm_s next_cur;

	always_comb begin
		next_cur = cur;
		// hold lets software change several bytes without the monitors
		// ever seeing a half-written value
		if (!hold_i) begin
			next_cur.held = live_i;
		end
		next_cur.khz = 17'(next_cur.held.multiplier) * `FREQ_STEP_KHZ;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign limits_o = cur.held;
	assign nominal_khz_o = cur.khz;
endmodule // limit_assembler

// file: src/reg_access_if.sv
/*
 One register access between the bus front end and the register store.
 Assumes req is a single-cycle strobe and rdata is combinational.
*/
`timescale 1ns/1ns
interface reg_access_if;
	import custom_a_pkg::*;
	logic req;
	logic we;
	logic lane_en;
	logic [7:0] index;
	byte_t wdata;
	byte_t rdata;
	modport bus_side (output req, output we, output lane_en, output index,
		output wdata, input rdata);
	modport reg_side (input req, input we, input lane_en, input index,
		input wdata, output rdata);
endinterface

// file: src/wb_frontend.sv
/*
 Classic Wishbone slave front end: one access per request, ack one cycle
 after the request is seen, ack held for one cycle only.
 Assumes the master drops cyc/stb for at least one cycle after ack.
*/
`timescale 1ns/1ns
module wb_frontend import custom_a_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	reg_access_if.bus_side acc
);
	typedef struct packed {
		bus_state_e state;
		logic ack;
		logic [31:0] dat;
	} front_s;

	front_s cur;
	front_s next_cur;

	always_comb begin
		next_cur = cur;
		acc.req = 1'b0;
		acc.we = wb_we_i;
		acc.lane_en = wb_sel_i[0];
		acc.index = wb_adr_i;
		acc.wdata = wb_dat_i[7:0];
		case (cur.state)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					acc.req = 1'b1;
					next_cur.state = BUS_ANSWER;
					next_cur.ack = 1'b1;
					next_cur.dat = wb_we_i ? 32'h00000000 : {24'h000000, acc.rdata};
				end
			end
			BUS_ANSWER: begin
				// ack lasts one cycle so a held stb is not taken twice
				next_cur.state = BUS_IDLE;
				next_cur.ack = 1'b0;
				next_cur.dat = 32'h00000000;
			end
			default: begin
				next_cur.state = BUS_IDLE;
				next_cur.ack = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur <= '{BUS_IDLE, 1'b0, 32'h00000000};
		end else begin
			cur <= next_cur;
		end
	end

	assign wb_ack_o = cur.ack;
	assign wb_dat_o = cur.dat;
endmodule // wb_frontend

// file: verification/custom_a_config_properties.sv
/* Port checker for custom_a_config.
 Assumes a classic Wishbone master with an idle cycle between accesses. */
`timescale 1ns/1ns
module custom_a_config_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [13:0] custom_a_multiplier_o,
	input wire logic [16:0] custom_a_nominal_khz_o,
	input wire logic [7:0] custom_a_single_cycle_min_o,
	input wire logic [7:0] custom_a_single_cycle_max_o,
	input wire logic [15:0] custom_a_cycle_freq_min_o,
	input wire logic [7:0] custom_a_cycle_freq_max_low_byte_o
);
	logic hold;
	wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire wr = take & wb_we_i & wb_sel_i[0] & !hold;
	wire [7:0] a = wb_adr_i;
	wire [7:0] d = wb_dat_i[7:0];
	// outputs freeze under hold, so write checks skip it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			hold <= 1'b0;
		else if (take && wb_we_i && wb_sel_i[0] && a == 8'hF0)
			hold <= d[0];
	end
	// ------
	// checks
	// ------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_mlo; wr && a == 8'h67 |-> ##2 custom_a_multiplier_o[7:0] == $past(d, 2); endproperty
	a_mlo: assert property (p_mlo) else $error("multiplier low byte");
	property p_mhi; wr && a == 8'h68 |-> ##2 custom_a_multiplier_o[13:8] == $past(d[5:0], 2);
	endproperty
	a_mhi: assert property (p_mhi) else $error("multiplier high bits");
	property p_nom; $stable(custom_a_multiplier_o) |->
		custom_a_nominal_khz_o == {custom_a_multiplier_o, 3'h0}; endproperty
	a_nom: assert property (p_nom) else $error("nominal frequency");
	property p_smin; wr && a == 8'h69 |-> ##2 custom_a_single_cycle_min_o == $past(d, 2); endproperty
	a_smin: assert property (p_smin) else $error("single cycle min");
	property p_smax; wr && a == 8'h6A |-> ##2 custom_a_single_cycle_max_o == $past(d, 2); endproperty
	a_smax: assert property (p_smax) else $error("single cycle max");
	property p_cflo; wr && a == 8'h6B |-> ##2 custom_a_cycle_freq_min_o[7:0] == $past(d, 2);
	endproperty
	a_cflo: assert property (p_cflo) else $error("cycle freq min low");
	property p_cfhi; wr && a == 8'h6C |-> ##2 custom_a_cycle_freq_min_o[15:8] == $past(d, 2)
		&& custom_a_cycle_freq_min_o[7:0] == $past(custom_a_cycle_freq_min_o[7:0], 2); endproperty
	a_cfhi: assert property (p_cfhi) else $error("cycle freq min high");
	property p_cmax; wr && a == 8'h6D |-> ##2
		custom_a_cycle_freq_max_low_byte_o == $past(d, 2); endproperty
	a_cmax: assert property (p_cmax) else $error("cycle freq max low");
	property p_rd; take && !wb_we_i |=> wb_dat_o[31:8] == 24'h0
		&& (wb_dat_o[7:6] == 2'h0 || $past(a) != 8'h68); endproperty
	a_rd: assert property (p_rd) else $error("reserved read bits");
	property p_hold; hold |=> $stable(custom_a_multiplier_o) && $stable(custom_a_single_cycle_min_o)
		&& $stable(custom_a_cycle_freq_min_o); endproperty
	a_hold: assert property (p_hold) else $error("outputs moved under hold");
	c_hold: cover property (hold && take && wb_we_i && a == 8'h69);
	c_wr_hi: cover property (wr && a == 8'h68);
	c_rd_hi: cover property (take && !wb_we_i && a == 8'h68);
	c_nosel: cover property (take && wb_we_i && !wb_sel_i[0]);
endmodule // custom_a_config_properties
bind custom_a_config custom_a_config_properties u_custom_a_config_properties (.*);

// file: verification/custom_a_config_tb.sv
/* Self-checking bench for custom_a_config over classic Wishbone.
 Assumes the slave acks every access it takes. */
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module custom_a_config_tb;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [9:2] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [13:0] custom_a_multiplier_o;
	logic [16:0] custom_a_nominal_khz_o;
	logic [7:0] custom_a_single_cycle_min_o, custom_a_single_cycle_max_o;
	logic [15:0] custom_a_cycle_freq_min_o;
	logic [7:0] custom_a_cycle_freq_max_low_byte_o;
	logic [7:0] pat [7] = '{8'hA5, 8'hFF, 8'h12, 8'hE7, 8'h34, 8'hC8, 8'h9B};
	int err_count, n_tests;
	custom_a_config u_custom_a_config (.*);
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// ---------
	// bus tasks
	// ---------
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		`CHK(n, 2)
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 4'hF);
		`CHK(q, {24'h0, e})
	endtask
	// ---------
	// scenarios
	// ---------
	task t_reset;
		for (int i = 0; i < 7; i++)
			rd(8'h67 + 8'(i), 8'h00);
		`CHK(custom_a_nominal_khz_o, 17'h0)
	endtask
	task t_all;
		for (int i = 0; i < 7; i++)
			acc(1'b1, 8'h67 + 8'(i), pat[i], 4'h1);
		for (int i = 0; i < 7; i++)
			rd(8'h67 + 8'(i), i == 1 ? 8'h3F : pat[i]);
		`CHK(custom_a_multiplier_o, 14'h3FA5)
		`CHK(custom_a_nominal_khz_o, 17'h1FD28)
		`CHK(custom_a_single_cycle_min_o, 8'h12)
		`CHK(custom_a_single_cycle_max_o, 8'hE7)
		`CHK(custom_a_cycle_freq_min_o, 16'hC834)
		`CHK(custom_a_cycle_freq_max_low_byte_o, 8'h9B)
	endtask
	// one byte at a time, lane 0 off, unmapped place, field limits
	task t_bytes;
		acc(1'b1, 8'h6B, 8'h00, 4'hE);
		rd(8'h6B, 8'h34);
		acc(1'b1, 8'h6C, 8'h01, 4'h1);
		acc(1'b1, 8'h10, 8'hFF, 4'hF);
		rd(8'h10, 8'h00);
		`CHK(custom_a_cycle_freq_min_o, 16'h0134)
		acc(1'b1, 8'h67, 8'h00, 4'h1);
		acc(1'b1, 8'h68, 8'hC0, 4'h1);
		rd(8'h68, 8'h00);
		`CHK(custom_a_multiplier_o, 14'h0000)
		`CHK(custom_a_nominal_khz_o, 17'h0)
		acc(1'b1, 8'h68, 8'h3F, 4'h1);
		acc(1'b1, 8'h67, 8'hFF, 4'h1);
		rd(8'h67, 8'hFF);
		`CHK(custom_a_nominal_khz_o, 17'h1FFF8)
	endtask
	// status flags, then hold freezes the monitors until released
	task t_ctrl;
		rd(8'hF1, 8'hFF);
		acc(1'b1, 8'hF1, 8'h7F, 4'h1);
		rd(8'hF1, 8'h00);
		acc(1'b1, 8'hF0, 8'h01, 4'h1);
		rd(8'hF0, 8'h01);
		acc(1'b1, 8'h69, 8'h5A, 4'h1);
		acc(1'b1, 8'h6C, 8'h77, 4'h1);
		rd(8'h69, 8'h5A);
		rd(8'hF1, 8'h24);
		`CHK(custom_a_single_cycle_min_o, 8'h12)
		`CHK(custom_a_cycle_freq_min_o, 16'h0134)
		acc(1'b1, 8'hF0, 8'h00, 4'h1);
		@(posedge clk_i);
		`CHK(custom_a_single_cycle_min_o, 8'h5A)
		`CHK(custom_a_cycle_freq_min_o, 16'h7734)
	endtask
	// reset in mid-run clears registers and outputs; checks four outputs and status, 0x68, 0x6C
	task t_rerst;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK(custom_a_multiplier_o, 14'h0000)
		`CHK(custom_a_nominal_khz_o, 17'h0)
		`CHK(custom_a_single_cycle_min_o, 8'h00)
		`CHK(custom_a_cycle_freq_min_o, 16'h0000)
		rd(8'hF1, 8'h00);
		rd(8'h68, 8'h00);
		rd(8'h6C, 8'h00);
	endtask
	task give_verdict;
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		err_count = 0;
		n_tests = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_all;
		t_bytes;
		t_ctrl;
		t_rerst;
		give_verdict;
	end
	// about 145 cycles of traffic; the limit leaves a wide margin
	initial begin
		#20000;
		err_count++;
		give_verdict;
	end
endmodule // custom_a_config_tb
